// ==== common/adc_defs.svh ====
// constants for the converter output block
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH
`define WORD_W          16
`define MOD_W           18
`define ACC_W           21
`define DECIM_SLOW      8
`define DECIM_FAST      4
`define SAMPLE_READY_N_HALF_SLOW  4
`define SAMPLE_READY_N_HALF_FAST  2
`define SETTLE_CYCLES   47
`define FIFO_DEPTH      32
`define CODE_MAX        16'h7FFF
`define CODE_MIN        16'h8000
`define CLK_PERIOD_NS   50
`endif

// ==== common/adc_pkg.sv ====
// types for the converter output block
`default_nettype none
package adc_pkg;
  typedef struct packed {
    logic        over;
    logic [15:0] code;
  } sample_word_t;

  typedef enum logic [1:0] {
    ST_CLEAR,
    ST_ARM,
    ST_LOW,
    ST_HIGH
  } ready_phase_t;
endpackage : adc_pkg
`default_nettype wire

// ==== dv/adc_output_reset_decimation_tb_top.sv ====
// testbench for the converter output block
`include "adc_defs.svh"
`default_nettype none
module adc_output_reset_decimation_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               filter_reset_n = 1'b0;
  logic               decim_select = 1'b0;
  logic               chip_select_n = 1'b1;
  logic               read_enable_n = 1'b1;
  logic               mod_valid = 1'b0;
  logic               mod_ready;
  logic [`MOD_W-1:0]  mod_sample = '0;
  logic               sample_ready_n;
  logic [`WORD_W-1:0] sample_word;
  logic               sample_word_oe;
  logic               over_range_flag;
  logic               data_unsettled;
  int                 fall_cnt;
  int                 low_len;
  int                 high_len;
  logic [`WORD_W-1:0] word_seen;
  logic               flag_seen;
  logic               held_bad;
  int                 error_cnt = 0;
  int                 samples_checked = 0;
  int                 idx = 0;
  int                 pat_base = 0;
  int                 pat_step = 0;

  adc_output_reset_decimation i_adc_output_reset_decimation (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .filter_reset_n(filter_reset_n),
    .decim_select(decim_select), .chip_select_n(chip_select_n),
    .read_enable_n(read_enable_n), .mod_valid(mod_valid), .mod_ready(mod_ready),
    .mod_sample(mod_sample), .sample_ready_n(sample_ready_n), .sample_word(sample_word),
    .sample_word_oe(sample_word_oe), .over_range_flag(over_range_flag),
    .data_unsettled(data_unsettled));

  adc_reader_model i_adc_reader_model (
    .ref_clk(ref_clk), .filter_reset_n(filter_reset_n), .sample_ready_n(sample_ready_n),
    .sample_word(sample_word), .sample_word_oe(sample_word_oe),
    .over_range_flag(over_range_flag), .fall_cnt(fall_cnt), .low_len(low_len),
    .high_len(high_len), .word_seen(word_seen), .flag_seen(flag_seen), .held_bad(held_bad));

  always #25 ref_clk = ~ref_clk;

  // index restarts with the filter so groups line up with the accumulator
  always @(posedge ref_clk) begin
    if (!filter_reset_n) begin
      idx <= 0;
    end else if (mod_valid && mod_ready) begin
      idx <= idx + 1;
    end
  end
  always @(negedge ref_clk) begin
    mod_sample <= `MOD_W'(pat_base + pat_step * (idx % 8));
  end

  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check_bit(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_word(string what, logic [`WORD_W-1:0] exp, logic [`WORD_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_count(string what, int exp, int got);
    samples_checked++;
    if (got != exp) begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_count

  task automatic wait_falls(int n);
    int target;
    int guard;
    target = fall_cnt + n;
    guard = 0;
    while (fall_cnt < target && guard < 100 * n) begin
      @(negedge ref_clk);
      guard++;
    end
    check_bit("strobe falls", 1'b1, fall_cnt >= target);
  endtask : wait_falls

  task automatic pulse_reset(logic sel);
    @(negedge ref_clk);
    filter_reset_n = 1'b0;
    decim_select = sel;
    #5;
    check_bit("ready in reset", 1'b1, sample_ready_n);
    check_word("word in reset", 16'h0000, sample_word);
    check_bit("flag in reset", 1'b0, over_range_flag);
    repeat (4) @(negedge ref_clk);
    check_bit("stream in clear", 1'b0, mod_ready);
    // release on a falling edge keeps recovery deterministic
    filter_reset_n = 1'b1;
    // two sync stages, then arm: strobe falls after the fourth rising edge
    repeat (3) @(negedge ref_clk);
    check_bit("ready before arm", 1'b1, sample_ready_n);
    @(negedge ref_clk);
    check_bit("ready after arm", 1'b0, sample_ready_n);
    check_bit("stream open", 1'b1, mod_ready);
  endtask : pulse_reset

  task automatic test_slow;
    pat_base = 32'h100;
    pat_step = 16;
    pulse_reset(1'b0);
    wait_falls(46);
    check_bit("unsettled early", 1'b1, data_unsettled);
    wait_falls(1);
    check_bit("unsettled late", 1'b0, data_unsettled);
    wait_falls(3);
    check_word("slow word", 16'h0138, word_seen);
    check_bit("slow flag", 1'b0, flag_seen);
    check_count("slow low", `SAMPLE_READY_N_HALF_SLOW, low_len);
    check_count("slow high", `SAMPLE_READY_N_HALF_SLOW, high_len);
    check_bit("word held", 1'b0, held_bad);
  endtask : test_slow

  task automatic test_fast;
    logic [`WORD_W-1:0] w0;
    pulse_reset(1'b1);
    wait_falls(50);
    w0 = word_seen;
    wait_falls(1);
    check_bit("fast pair", 1'b1, (w0 == 16'h0118 && word_seen == 16'h0158)
                                 || (w0 == 16'h0158 && word_seen == 16'h0118));
    check_count("fast low", `SAMPLE_READY_N_HALF_FAST, low_len);
    check_count("fast high", `SAMPLE_READY_N_HALF_FAST, high_len);
  endtask : test_fast

  task automatic test_saturate;
    int base [2] = '{131071, -131072};
    logic [`WORD_W-1:0] code [2] = '{`CODE_MAX, `CODE_MIN};
    pat_step = 0;
    for (int i = 0; i < 2; i++) begin
      pat_base = base[i];
      pulse_reset(1'b0);
      wait_falls(50);
      check_word("clipped word", code[i], word_seen);
      check_bit("clipped flag", 1'b1, flag_seen);
    end
  endtask : test_saturate

  task automatic test_bus;
    for (int i = 3; i >= 0; i--) begin
      @(negedge ref_clk);
      chip_select_n = i[1];
      read_enable_n = i[0];
      repeat (2) @(negedge ref_clk);
      check_bit("bus enable", i == 0, sample_word_oe);
    end
  endtask : test_bus

  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    mod_valid = 1'b1;
    test_bus();
    test_slow();
    test_fast();
    test_saturate();
    end_of_test();
  end
endmodule : adc_output_reset_decimation_tb_top
`default_nettype wire

// ==== dv/adc_reader_model.sv ====
// reader model: follows the ready strobe and takes words off the bus
`include "adc_defs.svh"
`default_nettype none
module adc_reader_model (
  // device pins
  input  wire logic               ref_clk,
  input  wire logic               filter_reset_n,
  input  wire logic               sample_ready_n,
  input  wire logic [`WORD_W-1:0] sample_word,
  input  wire logic               sample_word_oe,
  input  wire logic               over_range_flag,
  // observations
  output int                      fall_cnt,
  output int                      low_len,
  output int                      high_len,
  output logic      [`WORD_W-1:0] word_seen,
  output logic                    flag_seen,
  output logic                    held_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic               prev_n = 1'b1;
  logic [`WORD_W-1:0] last_word;
  int                 run = 0;
  // look between edges, where strobe and word have settled
  always @(negedge ref_clk) begin
    prev_n <= sample_ready_n;
    last_word <= sample_word;
    if (!filter_reset_n) begin
      fall_cnt <= 0;
      held_bad <= 1'b0;
    end else if (prev_n && !sample_ready_n) begin
      fall_cnt <= fall_cnt + 1;
      high_len <= run;
      run <= 1;
      // early words are still settling and are thrown away
      if (sample_word_oe && fall_cnt >= `SETTLE_CYCLES) begin
        word_seen <= sample_word;
        flag_seen <= over_range_flag;
      end
    end else begin
      if (!prev_n && sample_ready_n) begin
        low_len <= run;
        run <= 1;
      end else begin
        run <= run + 1;
      end
      // word forced low in reset may hold an old value until the first fall
      if (fall_cnt > 0 && sample_word !== last_word) begin
        held_bad <= 1'b1;
      end
    end
  end
endmodule : adc_reader_model
`default_nettype wire

// ==== src/adc_output_reset_decimation.sv ====
// converter output block: decimator, sample fifo, ready strobe and word bus
`include "adc_defs.svh"
`default_nettype none

module adc_sample_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;
  always_comb begin
    in_ready    = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    out_valid   = (wr_ptr != rd_ptr);
    out_data    = mem[rd_ptr[AW-1:0]];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = flush ? '0 : (push ? wr_ptr + 1'b1 : wr_ptr);
    next_rd_ptr = flush ? '0 : (pop ? rd_ptr + 1'b1 : rd_ptr);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
  // storage has no reset; pointers alone define content
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : adc_sample_fifo

module adc_output_reset_decimation (
  // clock and system reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // device pins
  input  wire logic                 filter_reset_n,
  input  wire logic                 decim_select,
  input  wire logic                 chip_select_n,
  input  wire logic                 read_enable_n,
  // modulator stream
  input  wire logic                 mod_valid,
  output logic                      mod_ready,
  input  wire logic [`MOD_W-1:0]    mod_sample,
  // reader side
  output logic                      sample_ready_n,
  output logic      [`WORD_W-1:0]   sample_word,
  output logic                      sample_word_oe,
  output logic                      over_range_flag,
  output logic                      data_unsettled
);
  // pin synchronisers: bit 0 reset, 1 chip select, 2 read, 3 decimation select
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta <= 4'h6;
      pin_sync <= 4'h6;
    end else begin
      pin_meta <= {decim_select, read_enable_n, chip_select_n, filter_reset_n};
      pin_sync <= pin_meta;
    end
  end
  logic filt_clear;
  logic decim_fast;
  assign filt_clear = !pin_sync[0];
  assign decim_fast = pin_sync[3];
  // decimating filter: boxcar sum, scaled and saturated
  logic signed [`ACC_W-1:0] acc;
  logic [2:0]               grp_cnt;
  logic signed [`ACC_W-1:0] next_acc;
  logic [2:0]               next_grp_cnt;
  logic signed [`ACC_W-1:0] total;
  logic signed [`ACC_W-1:0] scaled;
  logic [2:0]               grp_last;
  logic                     take;
  logic                     push_valid;
  adc_pkg::sample_word_t    push_word;
  logic                     fifo_in_ready;

  always_comb begin
    grp_last = decim_fast ? 3'(`DECIM_FAST - 1) : 3'(`DECIM_SLOW - 1);
    take     = mod_valid && fifo_in_ready && !filt_clear;
    total    = acc + {{(`ACC_W - `MOD_W){mod_sample[`MOD_W-1]}}, mod_sample};
    scaled   = decim_fast ? (total >>> 2) : (total >>> 3);
    push_valid = take && (grp_cnt >= grp_last);
    if (scaled > $signed({5'h00, `CODE_MAX})) begin
      push_word.code = `CODE_MAX;
      push_word.over = 1'b1;
    end else if (scaled < $signed({5'h1F, `CODE_MIN})) begin
      push_word.code = `CODE_MIN;
      push_word.over = 1'b1;
    end else begin
      push_word.code = scaled[`WORD_W-1:0];
      push_word.over = 1'b0;
    end
    next_acc     = acc;
    next_grp_cnt = grp_cnt;
    if (filt_clear) begin
      next_acc     = '0;
      next_grp_cnt = '0;
    end else if (push_valid) begin
      next_acc     = '0;
      next_grp_cnt = '0;
    end else if (take) begin
      next_acc     = total;
      next_grp_cnt = grp_cnt + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      acc     <= '0;
      grp_cnt <= '0;
    end else begin
      acc     <= next_acc;
      grp_cnt <= next_grp_cnt;
    end
  end
  // a full fifo stalls the modulator stream instead of dropping groups
  assign mod_ready = fifo_in_ready && !filt_clear;
  logic                  fifo_out_valid;
  logic                  fifo_pop;
  adc_pkg::sample_word_t fifo_out_word;
  adc_sample_fifo #(
    .WIDTH ($bits(adc_pkg::sample_word_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .flush     (filt_clear),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_word)
  );
  // ready strobe sequencer, output word and settling count
  adc_pkg::ready_phase_t phase;
  adc_pkg::ready_phase_t next_phase;
  logic [2:0]            ph_cnt;
  logic [2:0]            next_ph_cnt;
  logic [2:0]            ph_last;
  adc_pkg::sample_word_t word;
  adc_pkg::sample_word_t next_word;
  logic [5:0]            settle_cnt;
  logic [5:0]            next_settle_cnt;
  logic                  enter_low;

  always_comb begin
    ph_last     = decim_fast ? 3'(`SAMPLE_READY_N_HALF_FAST - 1) : 3'(`SAMPLE_READY_N_HALF_SLOW - 1);
    next_phase  = phase;
    next_ph_cnt = ph_cnt + 3'h1;
    enter_low   = 1'b0;
    case (phase)
      adc_pkg::ST_CLEAR: begin
        next_ph_cnt = '0;
        if (!filt_clear) begin
          next_phase = adc_pkg::ST_ARM;
        end
      end
      adc_pkg::ST_ARM: begin
        next_ph_cnt = '0;
        next_phase  = adc_pkg::ST_LOW;
        enter_low   = 1'b1;
      end
      adc_pkg::ST_LOW: begin
        if (ph_cnt >= ph_last) begin
          next_phase  = adc_pkg::ST_HIGH;
          next_ph_cnt = '0;
        end
      end
      adc_pkg::ST_HIGH: begin
        if (ph_cnt >= ph_last) begin
          next_phase  = adc_pkg::ST_LOW;
          next_ph_cnt = '0;
          enter_low   = 1'b1;
        end
      end
      default: begin
        next_phase  = adc_pkg::ST_CLEAR;
        next_ph_cnt = '0;
      end
    endcase
    // an empty fifo repeats the previous word rather than inventing one
    fifo_pop  = enter_low && !filt_clear;
    next_word = (fifo_pop && fifo_out_valid) ? fifo_out_word : word;
    next_settle_cnt = settle_cnt;
    if (enter_low && settle_cnt < 6'(`SETTLE_CYCLES)) begin
      next_settle_cnt = settle_cnt + 6'h01;
    end
    if (filt_clear) begin
      next_phase      = adc_pkg::ST_CLEAR;
      next_ph_cnt     = '0;
      next_word       = '0;
      next_settle_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phase      <= adc_pkg::ST_CLEAR;
      ph_cnt     <= '0;
      word       <= '0;
      settle_cnt <= '0;
    end else begin
      phase      <= next_phase;
      ph_cnt     <= next_ph_cnt;
      word       <= next_word;
      settle_cnt <= next_settle_cnt;
    end
  end
  // raw reset pin gates strobe, word and flag directly so the force needs no clock
  always_comb begin
    sample_ready_n  = !filter_reset_n || (phase != adc_pkg::ST_LOW);
    sample_word     = filter_reset_n ? word.code : '0;
    over_range_flag = filter_reset_n && word.over;
    sample_word_oe  = !pin_sync[1] && !pin_sync[2];
    data_unsettled  = settle_cnt < 6'(`SETTLE_CYCLES);
  end
  // checks: tally counts takes since the last push, sel_q spots a select move
  logic [3:0] tally;
  logic       sel_q;
  always_ff @(posedge ref_clk) begin
    sel_q <= decim_fast;
    if (sys_rst || filt_clear || push_valid) begin
      tally <= '0;
    end else if (take) begin
      tally <= tally + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  sequence s_low_run;
    !sample_ready_n [*4] ##1 sample_ready_n;
  endsequence
  sequence s_high_run;
    sample_ready_n [*4] ##1 !sample_ready_n;
  endsequence
  property p_reset_force;
    disable iff (sys_rst) !filter_reset_n |-> sample_ready_n && sample_word == '0;
  endproperty
  a_reset_force: assert property (p_reset_force) else $error("reset force missing");
  property p_release_low;
    disable iff (sys_rst || !filter_reset_n)
      $fell(filt_clear) |-> sample_ready_n ##1 sample_ready_n ##1 !sample_ready_n;
  endproperty
  a_release_low: assert property (p_release_low) else $error("ready not low on 2nd edge");
  property p_low_len;
    disable iff (sys_rst || filt_clear || !filter_reset_n || decim_fast)
      $fell(sample_ready_n) |-> s_low_run;
  endproperty
  a_low_len: assert property (p_low_len) else $error("ready low phase length wrong");
  property p_high_len;
    disable iff (sys_rst || filt_clear || !filter_reset_n || decim_fast)
      $rose(sample_ready_n) |-> s_high_run;
  endproperty
  a_high_len: assert property (p_high_len) else $error("ready high phase length wrong");
  property p_word_hold;
    disable iff (sys_rst || filt_clear || !filter_reset_n)
      $changed(word) |-> $fell(sample_ready_n);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word changed off ready edge");
  property p_flag_with_word;
    disable iff (sys_rst || filt_clear || !filter_reset_n)
      $changed(over_range_flag) |-> $fell(sample_ready_n);
  endproperty
  a_flag_with_word: assert property (p_flag_with_word) else $error("flag moved alone");
  property p_sat_pos;
    disable iff (sys_rst) push_valid && scaled > $signed({5'h00, `CODE_MAX})
      |-> push_word.code == 16'h7FFF && push_word.over;
  endproperty
  a_sat_pos: assert property (p_sat_pos) else $error("positive saturation wrong");
  property p_sat_neg;
    disable iff (sys_rst) push_valid && scaled < $signed({5'h1F, `CODE_MIN})
      |-> push_word.code == 16'h8000 && push_word.over;
  endproperty
  a_sat_neg: assert property (p_sat_neg) else $error("negative saturation wrong");
  property p_group_len;
    disable iff (sys_rst || filt_clear || (decim_fast != sel_q))
      push_valid |-> tally == (decim_fast ? 4'h3 : 4'h7);
  endproperty
  a_group_len: assert property (p_group_len) else $error("decimation group length wrong");
  property p_bus_off;
    disable iff (sys_rst) (chip_select_n || read_enable_n) [*3] |-> !sample_word_oe;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus driven while deselected");
  property p_settle;
    disable iff (sys_rst) $fell(data_unsettled) |-> $past(settle_cnt) == 6'h2E;
  endproperty
  a_settle: assert property (p_settle) else $error("settle count wrong");
endmodule : adc_output_reset_decimation
`default_nettype wire
